// ---- hdl/counter_regs.svh ----
// Purpose: register map, field positions and reset values of the counter
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: constants only; included by bare name
`ifndef COUNTER_REGS_SVH
`define COUNTER_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CTRL_OFS 32'h0000_0000
`define PRESET_OFS 32'h0000_0004
`define STATUS_OFS 32'h0000_0008
`define PRESCALE_OFS 32'h0000_000c

// ****************************************
// field positions
// ****************************************
`define CTRL_EN_P_BIT 0
`define CTRL_EN_T_BIT 1
`define CTRL_LOAD_N_BIT 2
`define CTRL_CLEAR_N_BIT 3
`define STATUS_CARRY_BIT 4

// ****************************************
// reset values and codes
// ****************************************
`define CTRL_RST 4'hc
`define PRESET_RST 4'h0
`define PRESCALE_RST 16'h0000
`define BIN_TERM 4'hf
`define DEC_TERM 4'h9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/counter_pkg.sv ----
// Purpose: types shared by the counter design files
// Assumes: counter_regs.svh holds all numeric constants
// Notes: bus channels travel as packed structs
package counter_pkg;

	// ****************************************
	// axi4-lite carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axil_rsp_s;

	// ****************************************
	// control fields, msb first
	// ****************************************
	typedef struct packed {
		logic clear_n;
		logic load_n;
		logic enable_t;
		logic enable_p;
	} ctrl_s;

	// ****************************************
	// module state
	// ****************************************
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tick_state_s;

	typedef struct packed {
		ctrl_s ctrl;
		logic [3:0] preset;
		logic [15:0] prescale;
		logic [3:0] count;
		logic aw_got;
		logic [31:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} core_state_s;

endpackage

// ---- hdl/count_tick_gen.sv ----
// Purpose: divider that makes the counting edge as a one-cycle enable
// Assumes: prescale 0 gives a tick on every clock
// Notes: tick is registered
`timescale 1ns/1ps
`include "counter_regs.svh"

module count_tick_gen
	import counter_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// divider
	input wire logic [15:0] prescale_i,
	output logic tick_o
);

	tick_state_s st_reg;
	tick_state_s st_next;

	always_comb begin
		st_next = st_reg;
		if (st_reg.cnt >= prescale_i) begin
			st_next.cnt = 16'h0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 16'h0001;
			st_next.tick = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;

endmodule // count_tick_gen

// ---- hdl/count_term_decode.sv ----
// Purpose: terminal count decode and gated ripple carry
// Assumes: count is the visible count, so an immediate clear also drops the carry
// Notes: purely combinational, one decode of the state
`timescale 1ns/1ps
`include "counter_regs.svh"

module count_term_decode #(
	parameter bit DECADE = 1'b0
) (
	// state in
	input wire logic [3:0] count_i,
	input wire logic enable_t_i,
	// decode out
	output logic terminal_o,
	output logic ripple_carry_o
);

	logic [3:0] term;

	assign term = DECADE ? `DEC_TERM : `BIN_TERM;
	assign terminal_o = (count_i == term);
	// single decode gated by the carry enable only
	assign ripple_carry_o = enable_t_i & terminal_o;

endmodule // count_term_decode

// ---- hdl/presettable_counter.sv ----
// Purpose: presettable 4-bit counter with AXI4-Lite control
// Assumes: one clock; counting edge is a tick from the divider
// Notes: DECADE selects ten states, ASYNC_CLEAR the immediate clear
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "counter_regs.svh"

module presettable_counter
	import counter_pkg::*;
#(
	parameter bit DECADE = 1'b0,
	parameter bit ASYNC_CLEAR = 1'b0
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// register bus
	input wire axil_req_s axil_req_i,
	output axil_rsp_s axil_rsp_o,
	// cascade
	input wire logic cascade_t_i,
	output logic ripple_carry_o,
	// count outputs
	output logic [3:0] count_o,
	output logic count_bit_lsb_o,
	output logic count_bit_msb_o
);

	// ****************************************
	// state and helpers
	// ****************************************
	core_state_s st_reg;
	core_state_s st_next;
	logic tick;
	logic terminal;
	logic enable_t_eff;
	logic clear_act;
	logic load_act;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [31:0] wr_addr;
	logic [31:0] rd_addr;

	assign clear_act = !st_reg.ctrl.clear_n;
	assign load_act = !st_reg.ctrl.load_n;
	assign enable_t_eff = st_reg.ctrl.enable_t & cascade_t_i;
	assign wr_addr = {st_reg.awaddr[31:2], 2'b00};
	assign rd_addr = {axil_req_i.araddr[31:2], 2'b00};

	// ****************************************
	// counting edge and decode
	// ****************************************
	count_tick_gen u_tick (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.prescale_i(st_reg.prescale),
		.tick_o(tick)
	);

	count_term_decode #(
		.DECADE(DECADE)
	) u_decode (
		.count_i(count_o),
		.enable_t_i(enable_t_eff),
		.terminal_o(terminal),
		.ripple_carry_o(ripple_carry_o)
	);

	// ****************************************
	// bus handshakes
	// ****************************************
	assign axil_rsp_o.awready = !st_reg.aw_got && !st_reg.bvalid;
	assign axil_rsp_o.wready = !st_reg.w_got && !st_reg.bvalid;
	assign axil_rsp_o.bvalid = st_reg.bvalid;
	assign axil_rsp_o.bresp = st_reg.bresp;
	assign axil_rsp_o.arready = !st_reg.rvalid;
	assign axil_rsp_o.rvalid = st_reg.rvalid;
	assign axil_rsp_o.rdata = st_reg.rdata;
	assign axil_rsp_o.rresp = st_reg.rresp;

	assign aw_take = axil_req_i.awvalid && axil_rsp_o.awready;
	assign w_take = axil_req_i.wvalid && axil_rsp_o.wready;
	assign ar_take = axil_req_i.arvalid && axil_rsp_o.arready;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next = st_reg;

		// counter core
		if (ASYNC_CLEAR && clear_act) begin
			st_next.count = 4'h0;
		end else if (tick) begin
			if (clear_act) begin
				st_next.count = 4'h0;
			end else if (load_act) begin
				st_next.count = st_reg.preset;
			end else if (st_reg.ctrl.enable_p && enable_t_eff) begin
				if (terminal) begin
					st_next.count = 4'h0;
				end else begin
					st_next.count = st_reg.count + 4'h1;
				end
			end
		end

		// write channel capture
		if (aw_take) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = axil_req_i.awaddr;
		end
		if (w_take) begin
			st_next.w_got = 1'b1;
			st_next.wdata = axil_req_i.wdata;
			st_next.wstrb = axil_req_i.wstrb;
		end

		// write commit; control levels may change at any time
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `RESP_OKAY;
			unique case (wr_addr)
				`CTRL_OFS: begin
					if (st_reg.wstrb[0]) begin
						st_next.ctrl.enable_p = st_reg.wdata[`CTRL_EN_P_BIT];
						st_next.ctrl.enable_t = st_reg.wdata[`CTRL_EN_T_BIT];
						st_next.ctrl.load_n = st_reg.wdata[`CTRL_LOAD_N_BIT];
						st_next.ctrl.clear_n = st_reg.wdata[`CTRL_CLEAR_N_BIT];
					end
				end
				`PRESET_OFS: begin
					if (st_reg.wstrb[0]) begin
						st_next.preset = st_reg.wdata[3:0];
					end
				end
				`STATUS_OFS: begin
					st_next.bresp = `RESP_OKAY;
				end
				`PRESCALE_OFS: begin
					if (st_reg.wstrb[0]) begin
						st_next.prescale[7:0] = st_reg.wdata[7:0];
					end
					if (st_reg.wstrb[1]) begin
						st_next.prescale[15:8] = st_reg.wdata[15:8];
					end
				end
				default: begin
					st_next.bresp = `RESP_SLVERR;
				end
			endcase
		end else if (st_reg.bvalid && axil_req_i.bready) begin
			st_next.bvalid = 1'b0;
		end

		// read channel
		if (ar_take) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `RESP_OKAY;
			st_next.rdata = 32'h0000_0000;
			unique case (rd_addr)
				`CTRL_OFS: begin
					st_next.rdata[3:0] = st_reg.ctrl;
				end
				`PRESET_OFS: begin
					st_next.rdata[3:0] = st_reg.preset;
				end
				`STATUS_OFS: begin
					st_next.rdata[3:0] = count_o;
					st_next.rdata[`STATUS_CARRY_BIT] = ripple_carry_o;
				end
				`PRESCALE_OFS: begin
					st_next.rdata[15:0] = st_reg.prescale;
				end
				default: begin
					st_next.rresp = `RESP_SLVERR;
				end
			endcase
		end else if (st_reg.rvalid && axil_req_i.rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
			st_reg.ctrl <= `CTRL_RST;
			st_reg.preset <= `PRESET_RST;
			st_reg.prescale <= `PRESCALE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// immediate clear masks the flops until the next edge zeroes them
	assign count_o = (ASYNC_CLEAR && clear_act) ? 4'h0 : st_reg.count;
	assign count_bit_lsb_o = count_o[0];
	assign count_bit_msb_o = count_o[3];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	logic [3:0] term_val;
	assign term_val = DECADE ? `DEC_TERM : `BIN_TERM;

	sequence s_load_edge;
		tick && load_act && !clear_act;
	endsequence

	sequence s_count_edge;
		tick && !load_act && !clear_act && st_reg.ctrl.enable_p && enable_t_eff;
	endsequence

	sequence s_write_pair;
		st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
	endsequence

	a_load_takes_data: assert property (
		s_load_edge |=> st_reg.count == $past(st_reg.preset)
	) else $error("load did not copy preset data");

	a_sync_clear_zero: assert property (
		(!ASYNC_CLEAR && tick && clear_act) |=> st_reg.count == 4'h0
	) else $error("synchronous clear did not zero the count");

	a_clear_over_load: assert property (
		(tick && clear_act && load_act) |=> count_o == 4'h0
	) else $error("load won over clear");

	a_count_advance: assert property (
		(s_count_edge and (st_reg.count != term_val))
			|=> st_reg.count == $past(st_reg.count) + 4'h1
	) else $error("enabled count did not advance by one");

	a_count_wrap: assert property (
		(s_count_edge and (st_reg.count == term_val)) |=> st_reg.count == 4'h0
	) else $error("terminal count did not wrap to zero");

	a_enable_hold: assert property (
		(tick && !load_act && !clear_act && !(st_reg.ctrl.enable_p && enable_t_eff))
			|=> $stable(st_reg.count)
	) else $error("count moved with an enable low");

	a_edge_only: assert property (
		(!tick && !(ASYNC_CLEAR && clear_act)) |=> $stable(st_reg.count)
	) else $error("count moved between counting edges");

	a_carry_gate: assert property (
		ripple_carry_o |-> (enable_t_eff && count_o == term_val)
	) else $error("ripple carry high outside terminal count");

	a_carry_width: assert property (
		($rose(ripple_carry_o) && tick && !load_act && !clear_act && st_reg.ctrl.enable_p
			&& enable_t_eff) |=> !ripple_carry_o
	) else $error("ripple carry outlasted one count step");

	a_async_clear: assert property (
		(ASYNC_CLEAR && clear_act) |-> count_o == 4'h0 ##1 st_reg.count == 4'h0
	) else $error("asynchronous clear did not force zero");

	a_write_resp: assert property (
		s_write_pair |=> st_reg.bvalid
	) else $error("write response missing after both channels");

	a_read_resp: assert property (
		ar_take |=> st_reg.rvalid
	) else $error("read data missing after address");

endmodule // presettable_counter

// ---- testbench/lower_stage_model.sv ----
// Purpose: lower cascaded stage feeding the carry enable of the counter
// Assumes: runs on the counter clock
// Notes: carry stays high while the stage is idle
`timescale 1ns/1ps

module lower_stage_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// control
	input wire logic run_i,
	// cascade out
	output logic carry_o
);
	logic [1:0] phase_reg;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= run_i ? phase_reg + 2'h1 : 2'h0;
		end
	end
	assign carry_o = run_i ? (phase_reg == 2'h3) : 1'b1;
endmodule // lower_stage_model

// ---- testbench/sync_presettable_4bit_counter_tb_top.sv ----
// Purpose: self-checking bench for a binary and a decade counter build
// Assumes: instance 0 binary sync clear, instance 1 decade async clear
// Notes: bready and rready stay high
`timescale 1ns/1ps
`include "counter_regs.svh"

module sync_presettable_4bit_counter_tb_top;
	import counter_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic run = 1'b0;
	logic cas;
	axil_req_s req [2];
	axil_rsp_s rsp [2];
	logic [3:0] cnt [2];
	logic rc [2];
	logic lsb [2];
	logic msb [2];
	int failures = 0;
	int tests_run = 0;
	logic [31:0] d;
	logic [1:0] r;
	logic [3:0] v;

	// ****************************************
	// design and far side
	// ****************************************
	for (genvar g = 0; g < 2; g++) begin : gen
		presettable_counter #(.DECADE(g == 1), .ASYNC_CLEAR(g == 1)) dut (
			.sys_clk_i(clk), .arst_n_i(arst_n), .axil_req_i(req[g]), .axil_rsp_o(rsp[g]),
			.cascade_t_i(cas), .ripple_carry_o(rc[g]), .count_o(cnt[g]),
			.count_bit_lsb_o(lsb[g]), .count_bit_msb_o(msb[g]));
	end
	lower_stage_model lower (.sys_clk_i(clk), .arst_n_i(arst_n), .run_i(run), .carry_o(cas));

	initial begin
		forever #5 clk = ~clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic stop_test();
		if (failures == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input int i, input logic [31:0] a, input logic [31:0] wd, input logic [1:0] er);
		bit aw;
		bit w;
		aw = 1'b0;
		w = 1'b0;
		req[i].awaddr <= a;
		req[i].awvalid <= 1'b1;
		req[i].wdata <= wd;
		req[i].wstrb <= 4'hf;
		req[i].wvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (rsp[i].bvalid) break;
			if (!aw && rsp[i].awready) begin
				aw = 1'b1;
				req[i].awvalid <= 1'b0;
			end
			if (!w && rsp[i].wready) begin
				w = 1'b1;
				req[i].wvalid <= 1'b0;
			end
		end
		check(rsp[i].bresp, er);
	endtask

	task automatic rd(input int i, input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		req[i].araddr <= a;
		req[i].arvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (rsp[i].rvalid) break;
			if (req[i].arvalid && rsp[i].arready) req[i].arvalid <= 1'b0;
		end
		check(rsp[i].rdata, ed);
		check(rsp[i].rresp, er);
	endtask

	task automatic load(input int i, input logic [3:0] lv);
		wr(i, `PRESET_OFS, {28'h0, lv}, `RESP_OKAY);
		wr(i, `CTRL_OFS, 32'h8, `RESP_OKAY);
		repeat (3) @(posedge clk);
		wr(i, `CTRL_OFS, 32'hc, `RESP_OKAY);
		rd(i, `STATUS_OFS, {28'h0, lv}, `RESP_OKAY);
	endtask

	task automatic run_check(input int i, input logic ep, input logic et, input int n);
		logic [3:0] e;
		logic [3:0] term;
		term = i ? `DEC_TERM : `BIN_TERM;
		@(posedge clk);
		e = cnt[i];
		repeat (n) begin
			check(rc[i], (e == term) & et & cas);
			e = (ep & et & cas) ? ((e == term) ? 4'h0 : e + 4'h1) : e;
			@(posedge clk);
			check(cnt[i], e);
			check({lsb[i], msb[i]}, {e[0], e[3]});
		end
	endtask

	task automatic wait_step(input int i);
		logic [3:0] o;
		o = cnt[i];
		do @(posedge clk); while (cnt[i] === o);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		req[0] = '0;
		req[1] = '0;
		req[0].bready = 1'b1;
		req[0].rready = 1'b1;
		req[1].bready = 1'b1;
		req[1].rready = 1'b1;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 2; i++) begin
			rd(i, `CTRL_OFS, 32'hc, `RESP_OKAY);
			rd(i, `PRESET_OFS, 32'h0, `RESP_OKAY);
			rd(i, `STATUS_OFS, 32'h0, `RESP_OKAY);
			rd(i, `PRESCALE_OFS, 32'h0, `RESP_OKAY);
			rd(i, 32'h10, 32'h0, `RESP_SLVERR);
			wr(i, 32'h10, 32'h5, `RESP_SLVERR);
			wr(i, `STATUS_OFS, 32'h1f, `RESP_OKAY);
			rd(i, `STATUS_OFS, 32'h0, `RESP_OKAY);
			wr(i, `PRESCALE_OFS, 32'h12345, `RESP_OKAY);
			rd(i, `PRESCALE_OFS, 32'h2345, `RESP_OKAY);
			wr(i, `PRESCALE_OFS, 32'h0, `RESP_OKAY);
			load(i, 4'h5);
			wr(i, `CTRL_OFS, 32'hf, `RESP_OKAY);
			run_check(i, 1'b1, 1'b1, 40);
			run <= 1'b1;
			run_check(i, 1'b1, 1'b1, 60);
			run <= 1'b0;
			// enable_p only, load and clear released
			wr(i, `CTRL_OFS, 32'hd, `RESP_OKAY);
			run_check(i, 1'b1, 1'b0, 12);
			// enable_t only, load and clear released
			wr(i, `CTRL_OFS, 32'he, `RESP_OKAY);
			run_check(i, 1'b0, 1'b1, 12);
			load(i, 4'h5);
			wr(i, `PRESCALE_OFS, 32'd49, `RESP_OKAY);
			wr(i, `CTRL_OFS, 32'hf, `RESP_OKAY);
			wait_step(i);
			v = cnt[i];
			check(v, 4'h6);
			wr(i, `CTRL_OFS, 32'h3, `RESP_OKAY);
			check(cnt[i], i ? 4'h0 : v);
			repeat (60) @(posedge clk);
			check(cnt[i], 4'h0);
			wr(i, `CTRL_OFS, 32'hf, `RESP_OKAY);
			wait_step(i);
			check(cnt[i], 4'h1);
			if (i == 0) begin
				// outside decode of count three drives clear low to shorten the cycle
				do wait_step(i); while (cnt[i] !== 4'h3);
				wr(i, `CTRL_OFS, 32'h7, `RESP_OKAY);
				wait_step(i);
				check(cnt[i], 4'h0);
				wr(i, `CTRL_OFS, 32'hf, `RESP_OKAY);
				wait_step(i);
				check(cnt[i], 4'h1);
			end
			wr(i, `PRESCALE_OFS, 32'h0, `RESP_OKAY);
		end
		stop_test();
	end

	initial begin
		#200000;
		failures++;
		stop_test();
	end
endmodule // sync_presettable_4bit_counter_tb_top
